// ### src/ebda_proc.sv
// processor end: address decode, bus arbitration, host hand-off
// ==================================================================
`timescale 1ns/1ps
`include "ebda_consts.svh"
module ebda_proc
(
   input wire logic mclk,
   input wire logic rst,
   ebda_if.proc bus,
   input wire ebda_pkg::ebda_id_t processor_identity,
   input wire logic want_bus,
   input wire logic want_lock,
   input wire logic xfer_busy,
   input wire logic xfer_burst,
   input wire ebda_pkg::ebda_addr_t xfer_addr,
   input wire ebda_pkg::ebda_addr_t slave_addr_start,
   input wire logic slave_addr_load,
   input wire logic slave_xfer_done,
   input wire logic strap_pin,
   output logic owner,
   output logic abort_xfer,
   output logic self_refresh_req,
   output logic strap_value,
   output ebda_pkg::ebda_addr_t slave_addr
);
   import ebda_pkg::*;
   // ==================================================================
   // pin synchronisers
   // request, host request, back-off and burst lines enter from pins
   ebda_req_t req_s;
   logic hreq_s;
   logic host_backoff_s;
   logic burst_s;
   ebda_sync #(.W(11), .INIT(11'h7ff)) u_sync
   (
      .mclk(mclk),
      .rst(rst),
      .d({bus.req_n, bus.host_request_n, bus.host_backoff_n,
          bus.consecutive_transfer_flag_n}),
      .q({req_s, hreq_s, host_backoff_s, burst_s})
   );
   // ==================================================================
   // identity and strap capture
   // both are straps, held steady while reset is high
   ebda_id_t my_id;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         my_id <= processor_identity;
         strap_value <= strap_pin;
      end
   end
   // ==================================================================
   // mastership tracking
   // every end sees the same synced request lines and so names the same
   // master; it keeps the bus until its own line goes high again, and
   // only then does the lowest active line take over
   ebda_req_t req_act;
   ebda_req_t my_line;
   ebda_req_t lowest_line;
   ebda_req_t master_line;
   ebda_req_t next_master_line;
   logic master_gone;
   logic mine;
   assign req_act = ~req_s;
   assign my_line = ebda_req_t'(9'h001 << my_id);
   assign lowest_line = req_act & (~req_act + 8'h01);
   assign master_gone = (master_line & req_act) == 8'h00;
   assign next_master_line = master_gone ? lowest_line : master_line;
   assign mine = next_master_line == my_line;
   always_ff @(posedge mclk)
   begin
      if (rst)
         master_line <= 8'h00;
      else
         master_line <= next_master_line;
   end
   // ==================================================================
   // arbitration
   ebda_state_t state;
   ebda_state_t next_state;
   logic my_req;
   logic [3:0] host_field;
   logic host_space;
   logic do_backoff;
   assign host_field = xfer_addr[`EBDA_HOST_HI:`EBDA_HOST_LO];
   assign host_space = host_field != `EBDA_HOST_ZERO;
   assign do_backoff = !host_backoff_s && host_space && xfer_busy;
   // a host request stops idle ends from taking the bus; the master
   // drains its transaction unless a back-off cuts a host-space one
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (!hreq_s)
               next_state = ST_IDLE;
            else if (want_bus && mine)
               next_state = ST_OWN;
         ST_OWN:
            if (!hreq_s)
               next_state = do_backoff ? ST_HOST : ST_DRAIN;
            else if (!want_bus && !xfer_busy)
               next_state = ST_IDLE;
         ST_DRAIN:
            if (!xfer_busy || do_backoff)
               next_state = ST_HOST;
         ST_HOST:
            if (hreq_s)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end
   // ==================================================================
   // outputs
   logic next_owner;
   logic next_grant;
   logic next_lock;
   logic in_charge;
   assign next_owner = (next_state == ST_OWN) || (next_state == ST_DRAIN);
   assign next_grant = next_state == ST_HOST;
   assign next_lock = want_lock && next_owner;
   assign in_charge = (state == ST_OWN) || (state == ST_DRAIN);
   // the line stays low for the whole tenure, so a busy master that no
   // longer wants the bus is not taken over mid-transaction
   assign my_req = want_bus || next_owner;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         owner <= 1'b0;
         bus.req_o <= '1;
         bus.req_oe <= '0;
         bus.host_grant_o <= 1'b1;
         bus.host_grant_oe <= 1'b0;
         bus.burst_oe <= 1'b0;
         bus.burst_o <= 1'b1;
         bus.lock_indicator_n <= 1'b1;
         bus.master_indicator_n <= 1'b1;
         abort_xfer <= 1'b0;
         self_refresh_req <= 1'b0;
      end
      else
      begin
         owner <= next_owner;
         // only our own line is driven, low when requesting
         bus.req_o <= ~(ebda_req_t'(my_req) << my_id);
         bus.req_oe <= my_line;
         bus.host_grant_o <= !next_grant;
         bus.host_grant_oe <= next_owner || next_grant;
         bus.burst_o <= !(xfer_burst && next_owner);
         bus.burst_oe <= next_owner;
         bus.lock_indicator_n <= !next_lock;
         bus.master_indicator_n <= !next_owner;
         abort_xfer <= in_charge && do_backoff;
         self_refresh_req <= next_grant;
      end
   end
   // ==================================================================
   // select decode, pure function of address
   // no register here, so the selects follow the address; valid while oe
   logic [5:0] bank_field;
   assign bank_field = xfer_addr[`EBDA_BANK_HI:`EBDA_BANK_LO];
   assign bus.bank0_select_n = !(bank_field == `EBDA_BANK0_CODE);
   assign bus.bank1_select_n = !(bank_field == `EBDA_BANK1_CODE);
   assign bus.host_space_select_n = !host_space;
   assign bus.selects_oe = owner;
   // ==================================================================
   // slave address counter for host bursts
   // advances per done only while the synced burst flag is low
   always_ff @(posedge mclk)
   begin
      if (rst)
         slave_addr <= '0;
      else if (slave_addr_load)
         slave_addr <= slave_addr_start;
      else if (slave_xfer_done && !burst_s)
         slave_addr <= slave_addr + 32'h1;
   end
endmodule

// ### common/ebda_consts.svh
// constants for the external bus decode and arbitration block
`ifndef EBDA_CONSTS_SVH
`define EBDA_CONSTS_SVH
`define EBDA_ADDR_W 32
`define EBDA_BANK_HI 31
`define EBDA_BANK_LO 26
`define EBDA_BANK0_CODE 6'h02
`define EBDA_BANK1_CODE 6'h03
`define EBDA_HOST_HI 31
`define EBDA_HOST_LO 28
`define EBDA_HOST_ZERO 4'h0
`define EBDA_NPROC 8
`define EBDA_ID_W 3
`endif

// ### common/ebda_pkg.sv
// types for the external bus decode and arbitration block
package ebda_pkg;
   typedef logic [31:0] ebda_addr_t;
   typedef logic [2:0] ebda_id_t;
   typedef logic [7:0] ebda_req_t;
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_OWN = 4'h2,
      ST_DRAIN = 4'h4,
      ST_HOST = 4'h8
   } ebda_state_t;
endpackage

// ### common/ebda_if.sv
// shared external bus wires between processor end and host end
`timescale 1ns/1ps
interface ebda_if;
   import ebda_pkg::*;
   // per-processor request lines, active low; the bench resolves the wire
   ebda_req_t req_o;
   ebda_req_t req_oe;
   ebda_req_t req_n;
   logic host_request_n;
   logic host_backoff_n;
   logic host_grant_o;
   logic host_grant_oe;
   logic host_grant_n;
   logic burst_o;
   logic burst_oe;
   logic host_burst_o;
   logic host_burst_oe;
   logic consecutive_transfer_flag_n;
   logic bank0_select_n;
   logic bank1_select_n;
   logic host_space_select_n;
   logic selects_oe;
   logic lock_indicator_n;
   logic master_indicator_n;
   modport proc
   (
      output req_o, req_oe, host_grant_o, host_grant_oe, burst_o, burst_oe,
      output bank0_select_n, bank1_select_n, host_space_select_n,
      output selects_oe, lock_indicator_n, master_indicator_n,
      input req_n, host_request_n, host_backoff_n, host_grant_n,
      input consecutive_transfer_flag_n
   );
   modport host
   (
      output host_request_n, host_backoff_n, host_burst_o, host_burst_oe,
      input host_grant_n, host_space_select_n, consecutive_transfer_flag_n
   );
endinterface

// ### src/ebda_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module ebda_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         meta <= INIT;
         q <= INIT;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ### src/ebda_host.sv
// host end: requests the bus, backs processors off, signals bursts
`timescale 1ns/1ps
module ebda_host
(
   input wire logic mclk,
   input wire logic rst,
   ebda_if.host bus,
   input wire logic want_bus,
   input wire logic force_backoff,
   input wire logic burst,
   output logic granted
);
   logic grant_s;
   ebda_sync #(.W(1), .INIT(1'b1)) u_sync
   (
      .mclk(mclk),
      .rst(rst),
      .d(bus.host_grant_n),
      .q(grant_s)
   );
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         bus.host_request_n <= 1'b1;
         bus.host_backoff_n <= 1'b1;
         bus.host_burst_o <= 1'b1;
         bus.host_burst_oe <= 1'b0;
         granted <= 1'b0;
      end
      else
      begin
         bus.host_request_n <= !want_bus;
         bus.host_backoff_n <= !(force_backoff && want_bus);
         granted <= !grant_s && want_bus;
         // drives burst only while it owns the bus
         bus.host_burst_oe <= !grant_s && want_bus;
         bus.host_burst_o <= !(burst && !grant_s && want_bus);
      end
   end
endmodule

// ### tb/ebda_asserts.sv
// concurrent checks on the wires between the two ends
`timescale 1ns/1ps
module ebda_asserts
(
   input wire logic mclk,
   input wire logic rst,
   input wire ebda_pkg::ebda_req_t req_oe,
   input wire logic host_request_n,
   input wire logic host_grant_n,
   input wire logic burst_oe,
   input wire logic bank0_select_n,
   input wire logic bank1_select_n,
   input wire logic host_space_select_n,
   input wire logic selects_oe,
   input wire logic lock_indicator_n,
   input wire logic master_indicator_n
);
   import ebda_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   one_line_a: assert property ($onehot0(req_oe))
      else $error("several request lines driven");
   master_flag_a: assert property (selects_oe == !master_indicator_n)
      else $error("master flag and select drive disagree");
   bank_excl_a: assert property (selects_oe |->
      bank0_select_n | bank1_select_n)
      else $error("both bank selects active");
   bank_host_a: assert property (selects_oe &&
      !(bank0_select_n && bank1_select_n) |-> host_space_select_n)
      else $error("host select with bank address");
   grant_release_a: assert property (!host_grant_n |-> !selects_oe)
      else $error("selects driven while host granted");
   grant_ack_a: assert property ($fell(host_grant_n) |->
      !host_request_n)
      else $error("grant without host request");
   grant_hold_a: assert property (!host_grant_n && !host_request_n
      |=> !host_grant_n)
      else $error("grant dropped while host requests");
   lock_master_a: assert property (!lock_indicator_n |-> selects_oe)
      else $error("lock shown by a non master");
   burst_master_a: assert property (burst_oe |-> selects_oe)
      else $error("burst driven by a non master");
endmodule

// ### tb/test_ext_bus_decode_arbitration.sv
// self-checking bench joining processor end and host end
`timescale 1ns/1ps
module test_ext_bus_decode_arbitration;
   import ebda_pkg::*;
   logic mclk = 0, rst = 1, wb = 1, wl = 0, bz = 0, xb = 0, sl = 0, sd = 0;
   logic sp = 0, hw = 0, hb = 0, hu = 0, own, ab, srq, stv, gr;
   ebda_id_t id = 3'h0;
   ebda_addr_t ad = 32'h0, ss = 32'h0, sa;
   ebda_req_t oth = 8'hff;
   int errors = 0, total_checks = 0;
   integer seed = 32'hdccd61c1;
   ebda_if bus_if();
   always #2 mclk = ~mclk;
   // resolved wires: low wins, released lines pulled high
   assign bus_if.req_n = oth & ~(bus_if.req_oe & ~bus_if.req_o);
   assign bus_if.host_grant_n = ~(bus_if.host_grant_oe & ~bus_if.host_grant_o);
   assign bus_if.consecutive_transfer_flag_n = ~(bus_if.burst_oe &
      ~bus_if.burst_o | bus_if.host_burst_oe & ~bus_if.host_burst_o);
   ebda_proc ebda_proc_inst (.mclk(mclk), .rst(rst), .bus(bus_if),
      .processor_identity(id), .want_bus(wb), .want_lock(wl), .xfer_busy(bz),
      .xfer_burst(xb), .xfer_addr(ad), .slave_addr_start(ss),
      .slave_addr_load(sl), .slave_xfer_done(sd), .strap_pin(sp),
      .owner(own), .abort_xfer(ab), .self_refresh_req(srq),
      .strap_value(stv), .slave_addr(sa));
   ebda_host ebda_host_inst (.mclk(mclk), .rst(rst), .bus(bus_if),
      .want_bus(hw), .force_backoff(hb), .burst(hu), .granted(gr));
   ebda_asserts ebda_asserts_inst (.mclk(mclk), .rst(rst),
      .req_oe(bus_if.req_oe), .host_request_n(bus_if.host_request_n),
      .host_grant_n(bus_if.host_grant_n), .burst_oe(bus_if.burst_oe),
      .bank0_select_n(bus_if.bank0_select_n),
      .bank1_select_n(bus_if.bank1_select_n),
      .host_space_select_n(bus_if.host_space_select_n),
      .selects_oe(bus_if.selects_oe),
      .lock_indicator_n(bus_if.lock_indicator_n),
      .master_indicator_n(bus_if.master_indicator_n));
   task automatic chk(string n, logic [31:0] s, logic [31:0] x);
      total_checks++;
      if (s !== x)
      begin
         errors++;
         $display("FAIL %s exp %h seen %h", n, x, s);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // model of the selects, active low: host, bank1, bank0
   function automatic logic [2:0] dec(ebda_addr_t a);
      dec = {a[31:28] == 4'h0, a[31:26] != 6'h03, a[31:26] != 6'h02};
   endfunction
   initial
   begin
      #8000;
      errors++;
      wrap_up;
   end
   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         rst = 1;
         id = ebda_id_t'(i);
         sp = i[0];
         oth = 8'hfe;
         wt(2);
         rst = 0;
         wt(8);
         chk("arb", own, i == 0);
         oth = 8'hff;
         wt(8);
         chk("req", bus_if.req_oe, 32'h1 << i);
         chk("own", own, 1);
         chk("strap", stv, sp);
      end
      $display("done arbitration");
      repeat (40)
      begin
         ad = $random(seed);
         if (ad[0])
            ad[31:26] = {5'h01, ad[1]};
         #1 chk("sel", {bus_if.host_space_select_n, bus_if.bank1_select_n,
            bus_if.bank0_select_n}, dec(ad));
         wt(1);
      end
      $display("done decode");
      wl = 1;
      bz = 1;
      xb = 1;
      ad = 32'h0800_0000;
      wt(4);
      chk("lock", bus_if.lock_indicator_n, 0);
      chk("burst", bus_if.consecutive_transfer_flag_n, 0);
      hb = 1;
      hw = 1;
      wt(8);
      chk("host_backoff", ab, 0);
      chk("drain", bus_if.host_grant_n, 1);
      ad = 32'h1000_0000;
      wt(1);
      chk("host_backoff", {ab, bus_if.host_grant_n}, 32'h2);
      {wl, xb, hb, bz, wb, hw} = 6'h00;
      wt(8);
      chk("rel", bus_if.selects_oe, 0);
      $display("done lock and back-off");
      wb = 1;
      bz = 1;
      wt(8);
      hw = 1;
      wt(8);
      chk("grant", bus_if.host_grant_n, 1);
      bz = 0;
      wt(8);
      chk("grant", {bus_if.host_grant_n, own, srq, gr}, 4'h3);
      ss = $random(seed);
      sl = 1;
      hu = 1;
      wt(4);
      sl = 0;
      repeat (5)
      begin
         sd = 1;
         wt(1);
         sd = 0;
         wt(1);
      end
      chk("count", sa, ss + 32'h5);
      {hu, hw} = 2'h0;
      wt(8);
      chk("grant", bus_if.host_grant_n, 1);
      $display("done host hand-off");
      wrap_up;
   end
endmodule
